/* bench/pes_host_model.sv */
// host-side partner: drives enable and warm reset pins, sees the open-drain outputs
module pes_host_model (
	input  wire logic       clock,
	input  wire logic [3:0] en_req,
	input  wire logic       warm_req,
	input  wire logic       system_reset_out_o,
	input  wire logic       system_reset_out_oe,
	input  wire logic       interrupt_out_o,
	input  wire logic       interrupt_out_oe,
	output logic            sys_conv_enable_pin = 1'b0,
	output logic            mem_conv_enable_pin = 1'b0,
	output logic            core_conv_enable_pin = 1'b0,
	output logic            linear_regs_enable_pin = 1'b0,
	output logic            warm_reset_in = 1'b0,
	output wire logic       reset_n,
	output wire logic       irq_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// any enable order the bench asks for is legal
	always @(posedge clock) begin
		{sys_conv_enable_pin, mem_conv_enable_pin, core_conv_enable_pin} <= en_req[3:1];
		linear_regs_enable_pin <= en_req[0];
		warm_reset_in <= warm_req;
	end
	// pull-ups: a released line reads high
	assign reset_n = system_reset_out_oe ? system_reset_out_o : 1'b1;
	assign irq_n = interrupt_out_oe ? interrupt_out_o : 1'b1;
endmodule // pes_host_model

/* bench/pes_supervisor_chk.sv */
// port-level assertion checker for the supervisor
module pes_chk #(
	parameter int HOLD_COUNT     = 20,
	parameter int DEBOUNCE_COUNT = 10
) (
	input wire logic               clock,
	input wire logic               rst,
	input wire logic               mem_conv_enable_pin,
	input wire logic               supply_undervoltage_lock,
	input wire logic               thermal_trip,
	input wire logic               backup_rail_good,
	input wire logic               warm_reset_in,
	input wire logic               core_default_select,
	input wire logic               power_fail_sense,
	input wire pes_pkg::pes_rail_t rail_on,
	input wire logic [2:0]         discharge_on,
	input wire logic [4:0]         core_voltage_code,
	input wire logic               power_fail_flag,
	input wire logic               system_reset_out_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] bcnt_q;
	logic [7:0] wcnt_q;
	// saturating run lengths, so long idle stretches never wrap back into range
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bcnt_q <= 8'h00;
			wcnt_q <= 8'h00;
		end else begin
			bcnt_q <= (backup_rail_good && !warm_reset_in) ? bcnt_q + 8'(bcnt_q != 8'hff) : 8'h00;
			wcnt_q <= warm_reset_in ? wcnt_q + 8'(wcnt_q != 8'hff) : 8'h00;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_CONV_EN: assert property ((mem_conv_enable_pin && !supply_undervoltage_lock && !thermal_trip)[*7]
		|-> rail_on.mem) else $error("memory rail not on");
	AST_FAULT_OFF: assert property ((supply_undervoltage_lock || thermal_trip)[*7] |-> rail_on == 5'h00)
		else $error("rails on during fault");
	AST_DISCH_OFF: assert property (rail_on.sys[*3] |-> !discharge_on[2]) else $error("discharge on live rail");
	AST_BKUP_RST: assert property (!backup_rail_good[*7] |-> system_reset_out_oe) else $error("reset not held");
	AST_HOLD: assert property (!backup_rail_good[*8] ##1 backup_rail_good |-> system_reset_out_oe[*8])
		else $error("reset released early");
	AST_RELEASE: assert property (bcnt_q > HOLD_COUNT + DEBOUNCE_COUNT + 8 |-> !system_reset_out_oe)
		else $error("reset stuck");
	AST_WARM: assert property (wcnt_q > DEBOUNCE_COUNT + 6 |-> system_reset_out_oe) else $error("warm reset lost");
	AST_CORE_DEF: assert property (system_reset_out_oe[*8] |-> core_voltage_code ==
		(core_default_select ? pes_pkg::CORE_DEF_HI : pes_pkg::CORE_DEF_LO)) else $error("core code not default");
	AST_SYS_OFF: assert property ((!rail_on.sys && rail_on.core && !system_reset_out_oe)[*3]
		|-> core_voltage_code[4] && !core_voltage_code[0]) else $error("core code pattern wrong");
	AST_PFAIL: assert property (power_fail_sense[*7] |-> power_fail_flag) else $error("power fail flag low");
	cover property (system_reset_out_oe ##1 !system_reset_out_oe);
	cover property (discharge_on != 3'h0);
	cover property (!rail_on.sys && rail_on.core);
endmodule // pes_chk

/* bench/tb.sv */
// self-checking testbench for the supervisor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 20;
	localparam int DEB = 10;
	logic clock = 0;
	logic rst = 1;
	logic [4:0] avs_address = '0;
	logic avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	logic core_default_select = 1, supply_undervoltage_lock = 0, thermal_trip = 0;
	logic backup_rail_good = 0, power_fail_sense = 0, battery_low_sense = 0;
	pes_pkg::pes_rail_t rail_low_raw = '0, rail_on;
	logic [2:0] discharge_on, linear_level_a, linear_level_b;
	logic [4:0] core_voltage_code;
	logic power_fail_flag, battery_low_flag, system_reset_out_o, system_reset_out_oe;
	logic interrupt_out_o, interrupt_out_oe, reset_n, irq_n, warm_req = 0;
	logic sys_conv_enable_pin, mem_conv_enable_pin, core_conv_enable_pin, linear_regs_enable_pin, warm_reset_in;
	logic [3:0] en_req = '0;
	int error_cnt = 0;
	int comparisons = 0;
	pes_supervisor #(.HOLD_COUNT(HOLD), .DEBOUNCE_COUNT(DEB)) dut_u (.*);
	pes_host_model host_u (.*);
	always #5 clock = ~clock;
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// settle: pins pass a synchroniser before reaching registered outputs
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask
	// request stands until waitrequest is seen low at a rising edge; the watchdog ends a hang
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wait_rel;
		int n;
		n = 0;
		while (reset_n !== 1'b1 && n < 200) begin
			wt(1);
			n++;
		end
		chk("hold", n >= HOLD && n <= HOLD + 12, 1);
	endtask
	task automatic t_reset;
		wt(10);
		chk("reset_low", reset_n, 0);
		chk("core_rst", core_voltage_code, pes_pkg::CORE_DEF_HI);
		@(posedge clock);
		backup_rail_good <= 1;
		wait_rel();
		$display("reset test done");
	endtask
	task automatic t_regs;
		@(posedge clock);
		rail_low_raw <= '1;
		bus(0, pes_pkg::OFF_DISCHARGE, 0);
		chk("dis_rst", q, 0);
		bus(0, pes_pkg::OFF_MASK, 0);
		chk("mask_rst", q, 0);
		bus(1, pes_pkg::OFF_STATUS, 32'hffff);
		bus(0, pes_pkg::OFF_STATUS, 0);
		chk("stat_off", q, 0);
		bus(0, 5'h1c, 0);
		chk("unmapped", q, pes_pkg::UNMAPPED_RD);
		rail_low_raw <= '0;
		$display("register test done");
	endtask
	task automatic t_enab;
		@(posedge clock);
		en_req <= 4'hf;
		wt(8);
		chk("all_on", rail_on, 5'h1f);
		bus(1, pes_pkg::OFF_LINEAR, 32'h531);
		wt(8);
		chk("lin", {linear_level_b, linear_level_a, rail_on}, 11'h57e);
		bus(1, pes_pkg::OFF_LINEAR, 0);
		supply_undervoltage_lock <= 1;
		wt(8);
		chk("lockout", rail_on, 0);
		@(posedge clock);
		supply_undervoltage_lock <= 0;
		thermal_trip <= 1;
		wt(8);
		chk("therm", rail_on, 0);
		@(posedge clock);
		thermal_trip <= 0;
		en_req <= 4'hb;
		wt(8);
		chk("mem_off", rail_on, 5'h17);
		$display("enable test done");
	endtask
	task automatic t_irq;
		@(posedge clock);
		en_req <= 4'hf;
		wt(8);
		chk("irq_idle", irq_n, 1);
		@(posedge clock);
		rail_low_raw.mem <= 1;
		wt(8);
		chk("irq", irq_n, 0);
		bus(0, pes_pkg::OFF_STATUS, 0);
		chk("stat", q, 32'h10);
		wt(4);
		chk("blocked", irq_n, 1);
		bus(1, pes_pkg::OFF_MASK, 32'h4);
		rail_low_raw <= 5'h04;
		wt(8);
		chk("masked", irq_n, 1);
		@(posedge clock);
		rail_low_raw <= 5'h05;
		wt(8);
		chk("unmasked", irq_n, 0);
		bus(1, pes_pkg::OFF_MASK, 0);
		rail_low_raw <= '0;
		$display("interrupt test done");
	endtask
	task automatic t_dis;
		bus(1, pes_pkg::OFF_DISCHARGE, 32'h5);
		en_req <= 4'h5;
		wt(8);
		chk("dis_on", discharge_on, 3'h5);
		@(posedge clock);
		en_req <= 4'hf;
		wt(8);
		chk("dis_off", discharge_on, 3'h0);
		$display("discharge test done");
	endtask
	task automatic t_core;
		bus(1, pes_pkg::OFF_CORE, 32'h0e);
		bus(0, pes_pkg::OFF_CORE, 0);
		chk("code_wr", q, 32'h0e);
		en_req <= 4'h7;
		wt(8);
		chk("sys_off", core_voltage_code, 5'h1e);
		@(posedge clock);
		en_req <= 4'h5;
		wt(8);
		chk("both_off", core_voltage_code, pes_pkg::CORE_DEF_HI);
		@(posedge clock);
		en_req <= 4'hf;
		wt(8);
		bus(1, pes_pkg::OFF_CORE, 32'h07);
		core_default_select <= 1'b0;
		supply_undervoltage_lock <= 1;
		wt(8);
		@(posedge clock);
		supply_undervoltage_lock <= 0;
		wt(8);
		chk("lock_code", core_voltage_code, pes_pkg::CORE_DEF_LO);
		@(posedge clock);
		core_default_select <= 1'b1;
		$display("core code test done");
	endtask
	task automatic t_warm;
		bus(1, pes_pkg::OFF_CORE, 32'h03);
		warm_req <= 1;
		wt(DEB - 4);
		@(posedge clock);
		warm_req <= 0;
		wt(20);
		chk("glitch", reset_n, 1);
		@(posedge clock);
		warm_req <= 1;
		wt(DEB + 8);
		chk("warm", reset_n, 0);
		chk("warm_code", core_voltage_code, pes_pkg::CORE_DEF_HI);
		@(posedge clock);
		warm_req <= 0;
		wt(DEB + 8);
		chk("warm_rel", reset_n, 1);
		bus(0, pes_pkg::OFF_DISCHARGE, 0);
		chk("cfg_kept", q, 32'h5);
		$display("warm reset test done");
	endtask
	task automatic t_flags;
		@(posedge clock);
		power_fail_sense <= 1;
		wt(8);
		chk("pf", {power_fail_flag, battery_low_flag}, 2'b10);
		bus(0, pes_pkg::OFF_STATUS, 0);
		chk("pf_stat", q[7:6], 2'b10);
		power_fail_sense <= 0;
		battery_low_sense <= 1;
		wt(8);
		chk("bl", {power_fail_flag, battery_low_flag}, 2'b01);
		$display("flag test done");
	endtask
	task automatic finish_test;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 0;
		t_reset();
		t_regs();
		t_enab();
		t_irq();
		t_dis();
		t_core();
		t_warm();
		t_flags();
		finish_test();
	end
	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		#100us;
		error_cnt++;
		$display("Error watchdog expected done seen hang");
		finish_test();
	end
endmodule // tb
bind pes_supervisor pes_chk #(.HOLD_COUNT(HOLD_COUNT), .DEBOUNCE_COUNT(DEBOUNCE_COUNT)) chk_u (.*);

/* common/pes_pkg.sv */
// shared constants and types for the power enable and reset supervisor
package pes_pkg;
	// ***************************************************
	// register map (byte offsets)
	// ***************************************************
	localparam logic [4:0] OFF_STATUS    = 5'h00;
	localparam logic [4:0] OFF_DISCHARGE = 5'h04;
	localparam logic [4:0] OFF_LINEAR    = 5'h08;
	localparam logic [4:0] OFF_MASK      = 5'h0c;
	localparam logic [4:0] OFF_CORE      = 5'h10;
	localparam logic [31:0] UNMAPPED_RD  = 32'h0000_00ff;

	// ***************************************************
	// field positions and reset values
	// ***************************************************
	localparam int STAT_PFAIL   = 7;
	localparam int STAT_BATLOW  = 6;
	localparam int STAT_RAIL_LO = 1;
	localparam int LIN_DIS_A    = 0;
	localparam int LIN_DIS_B    = 1;
	localparam int LIN_LVL_A    = 4;
	localparam int LIN_LVL_B    = 8;
	localparam logic [2:0]  DISCHARGE_RST = 3'h0;
	localparam logic [10:0] LINEAR_RST    = 11'h000;
	localparam logic [4:0]  MASK_RST      = 5'h00;
	localparam logic [4:0]  CORE_DEF_LO   = 5'h0a;
	localparam logic [4:0]  CORE_DEF_HI   = 5'h14;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int CLK_MHZ       = 100;
	localparam int HOLD_MS       = 100;
	localparam int DEBOUNCE_MS   = 30;
	localparam int HOLD_CYCLES   = HOLD_MS * 1000 * CLK_MHZ;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;
	localparam int CNT_W         = 24;

	// ***************************************************
	// types
	// ***************************************************
	typedef struct packed {
		logic sys;
		logic mem;
		logic core;
		logic lin_b;
		logic lin_a;
	} pes_rail_t;
endpackage

/* rtl/pes_supervisor.sv */
// power enable, discharge, power-good, interrupt and system reset supervisor
// What this block does
// - each converter has its own enable pin; 0 disables, 1 enables it
// - per-converter discharge is off after reset, on while enabled bit and converter off
// - every rail reports power-good in status; any rail low raises the interrupt
// - disabled converter: comparator ignored, status bit reports good
// - disabled linear regulator: comparator ignored, status bit reports good
// - one pin enables both linear regulators; software may disable or set level
// - lockout or thermal trip forces all converters and regulators off
// - system reset low at power-up, while backup rail bad, and hold time after
// - reset hold time is configurable, default 100 ms
// - system reset is open-drain active low; warm reset also forces it low
// - warm reset input is debounced with a 30 ms filter
// - warm reset keeps configuration, only reloads core code from its default pin
// - core code returns to default on warm, backup bad, lockout, reset, both off
// - system converter off makes core code 1xxx0, middle bits kept
// - power-fail and battery-low flags follow their below-threshold detectors
// - interrupt combines rail indications; bits active at a status read are blocked
// - mask register suppresses rail interrupts; nothing masked after reset
module pes_supervisor #(
	parameter int HOLD_COUNT     = pes_pkg::HOLD_CYCLES,
	parameter int DEBOUNCE_COUNT = pes_pkg::DEBOUNCE_CYCLES
) (
	input  wire logic              clock,
	input  wire logic              rst,
	// avalon-mm slave
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// pins
	input  wire logic              sys_conv_enable_pin,
	input  wire logic              mem_conv_enable_pin,
	input  wire logic              core_conv_enable_pin,
	input  wire logic              linear_regs_enable_pin,
	input  wire logic              warm_reset_in,
	input  wire logic              core_default_select,
	input  wire logic              supply_undervoltage_lock,
	input  wire logic              thermal_trip,
	input  wire logic              backup_rail_good,
	input  wire logic              power_fail_sense,
	input  wire logic              battery_low_sense,
	input  wire pes_pkg::pes_rail_t rail_low_raw,
	// outputs
	output pes_pkg::pes_rail_t     rail_on,
	output logic [2:0]             discharge_on,
	output logic [2:0]             linear_level_a,
	output logic [2:0]             linear_level_b,
	output logic [4:0]             core_voltage_code,
	output logic                   power_fail_flag,
	output logic                   battery_low_flag,
	output logic                   system_reset_out_o,
	output logic                   system_reset_out_oe,
	output logic                   interrupt_out_o,
	output logic                   interrupt_out_oe
);
	// ***************************************************
	// input synchronisers
	// ***************************************************
	localparam int NIN = 16;
	logic [NIN-1:0] pins_raw;
	logic [NIN-1:0] s1_q;
	logic [NIN-1:0] s2_q;
	logic [NIN-1:0] s3_q;
	logic [NIN-1:0] pin_q;

	assign pins_raw = {sys_conv_enable_pin, mem_conv_enable_pin, core_conv_enable_pin,
		linear_regs_enable_pin, warm_reset_in, core_default_select, supply_undervoltage_lock,
		thermal_trip, backup_rail_good, power_fail_sense, battery_low_sense, rail_low_raw};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			pin_q <= '0;
		end else begin
			s1_q  <= pins_raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			// a bit moves only when the second and third stages agree
			pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
		end
	end

	wire logic en_sys    = pin_q[15];
	wire logic en_mem    = pin_q[14];
	wire logic en_core   = pin_q[13];
	wire logic en_lin    = pin_q[12];
	wire logic warm_raw  = pin_q[11];
	wire logic def_sel   = pin_q[10];
	wire logic uv_lock   = pin_q[9];
	wire logic hot       = pin_q[8];
	wire logic bkp_good  = pin_q[7];
	wire logic pf_low    = pin_q[6];
	wire logic bl_low    = pin_q[5];
	wire pes_pkg::pes_rail_t rail_low = pes_pkg::pes_rail_t'(pin_q[4:0]);

	// ***************************************************
	// registers
	// ***************************************************
	logic [2:0]  discharge_q;
	logic [10:0] linear_q;
	logic [4:0]  mask_q;
	logic [4:0]  core_q;
	logic [4:0]  core_d;
	logic [4:0]  blocked_q;
	logic        ack_q;
	logic [31:0] rdata_q;

	wire logic req      = avs_read | avs_write;
	wire logic wr_fire  = avs_write & ack_q;
	wire logic rd_fire  = avs_read & ack_q;
	wire logic hit_stat = avs_address == pes_pkg::OFF_STATUS;
	wire logic hit_dis  = avs_address == pes_pkg::OFF_DISCHARGE;
	wire logic hit_lin  = avs_address == pes_pkg::OFF_LINEAR;
	wire logic hit_mask = avs_address == pes_pkg::OFF_MASK;
	wire logic hit_core = avs_address == pes_pkg::OFF_CORE;

	// ***************************************************
	// rail control
	// ***************************************************
	wire logic lockout = uv_lock | hot;
	wire logic lin_a_on = en_lin & ~linear_q[pes_pkg::LIN_DIS_A] & ~lockout;
	wire logic lin_b_on = en_lin & ~linear_q[pes_pkg::LIN_DIS_B] & ~lockout;
	// faults override every enable, the software disable bits included
	wire pes_pkg::pes_rail_t on_now = '{
		sys:   en_sys & ~lockout,
		mem:   en_mem & ~lockout,
		core:  en_core & ~lockout,
		lin_b: lin_b_on,
		lin_a: lin_a_on
	};

	// disabled rails report good regardless of their comparator
	wire logic [4:0] rail_bad = rail_low & on_now;
	wire logic [7:0] status = {pf_low, bl_low, rail_bad, 1'b0};

	// ***************************************************
	// warm reset debounce
	// ***************************************************
	// a glitch shorter than the filter count never reaches the reset logic
	logic [pes_pkg::CNT_W-1:0] deb_cnt_q;
	logic                      warm_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			deb_cnt_q <= '0;
			warm_q    <= 1'b0;
		end else if (warm_raw == warm_q) begin
			deb_cnt_q <= '0;
		end else if (deb_cnt_q >= pes_pkg::CNT_W'(DEBOUNCE_COUNT - 1)) begin
			warm_q    <= warm_raw;
			deb_cnt_q <= '0;
		end else begin
			deb_cnt_q <= deb_cnt_q + 1'b1;
		end
	end

	// ***************************************************
	// system reset hold
	// ***************************************************
	// a backup dip mid-count reloads the full hold time, never a partial one
	logic [pes_pkg::CNT_W-1:0] hold_cnt_q;
	logic                      sysrst_q;
	wire logic hold_busy = hold_cnt_q != '0;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hold_cnt_q <= pes_pkg::CNT_W'(HOLD_COUNT);
		end else if (!bkp_good) begin
			hold_cnt_q <= pes_pkg::CNT_W'(HOLD_COUNT);
		end else if (hold_busy) begin
			hold_cnt_q <= hold_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sysrst_q <= 1'b1;
		end else begin
			sysrst_q <= ~bkp_good | hold_busy | warm_q;
		end
	end

	// ***************************************************
	// core voltage code
	// ***************************************************
	wire logic [4:0] core_def = def_sel ? pes_pkg::CORE_DEF_HI : pes_pkg::CORE_DEF_LO;
	wire logic core_to_def = warm_q | ~bkp_good | uv_lock | sysrst_q | (~on_now.core & ~on_now.sys);

	// sys-off pattern lands on top of a same-cycle software write
	always_comb begin
		core_d = core_q;
		if (wr_fire && hit_core) begin
			core_d = avs_writedata[4:0];
		end
		if (core_to_def) begin
			core_d = core_def;
		end else if (!on_now.sys) begin
			core_d = {1'b1, core_d[3:1], 1'b0};
		end
	end

	// ***************************************************
	// software registers and interrupt blocking
	// ***************************************************
	// config registers only follow rst, so warm reset leaves them intact
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			discharge_q <= pes_pkg::DISCHARGE_RST;
			linear_q    <= pes_pkg::LINEAR_RST;
			mask_q      <= pes_pkg::MASK_RST;
			core_q      <= pes_pkg::CORE_DEF_LO;
		end else begin
			core_q <= core_d;
			if (wr_fire && hit_dis) begin
				discharge_q <= avs_writedata[2:0];
			end
			if (wr_fire && hit_lin) begin
				linear_q <= avs_writedata[10:0];
			end
			if (wr_fire && hit_mask) begin
				mask_q <= avs_writedata[4:0];
			end
		end
	end

	// a block drops as soon as its rail recovers, so a new fault interrupts again
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			blocked_q <= '0;
		end else begin
			blocked_q <= (blocked_q | ((rd_fire && hit_stat) ? rail_bad : 5'h00)) & rail_bad;
		end
	end

	// ***************************************************
	// avalon slave: one wait state per access
	// ***************************************************
	// the wait state lets readdata come straight from a flop, traded against throughput
	wire logic [31:0] rd_mux =
		hit_stat ? {24'h000000, status} :
		hit_dis  ? {29'h0, discharge_q} :
		hit_lin  ? {21'h0, linear_q} :
		hit_mask ? {27'h0, mask_q} :
		hit_core ? {27'h0, core_q} :
		pes_pkg::UNMAPPED_RD;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			ack_q <= req & ~ack_q;
			if (avs_read && !ack_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;

	// ***************************************************
	// outputs
	// ***************************************************
	logic              irq_q;
	pes_pkg::pes_rail_t on_q;
	logic [2:0]        dis_q;
	logic [1:0]        flags_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_q   <= 1'b0;
			on_q    <= '0;
			dis_q   <= '0;
			flags_q <= '0;
		end else begin
			irq_q   <= |(rail_bad & ~mask_q & ~blocked_q);
			on_q    <= on_now;
			dis_q   <= discharge_q & ~{on_now.sys, on_now.mem, on_now.core};
			flags_q <= {pf_low, bl_low};
		end
	end

	assign rail_on             = on_q;
	assign discharge_on        = dis_q;
	assign linear_level_a      = linear_q[pes_pkg::LIN_LVL_A +: 3];
	assign linear_level_b      = linear_q[pes_pkg::LIN_LVL_B +: 3];
	assign core_voltage_code   = core_q;
	assign power_fail_flag     = flags_q[1];
	assign battery_low_flag    = flags_q[0];
	// open-drain pins: data leg tied low, the enable pulls the line
	assign system_reset_out_o  = 1'b0;
	assign system_reset_out_oe = sysrst_q;
	assign interrupt_out_o     = 1'b0;
	assign interrupt_out_oe    = irq_q;
endmodule // pes_supervisor
